// >>> src/homing_reference_control.sv
// Functional notes
// - Method 0 disables homing; 1 homes on negative limit, 2 positive, both with index.
// - Methods 7-14 use reference switch plus index; 7-10 search positive, 11-14 negative.
// - Method 17 homes on negative limit, 18 positive limit, no index pulse.
// - Methods 23-30 use reference switch without index; lower half positive, upper negative.
// - Method 31 homes on index alone moving negative, 34 moving positive.
// - Inverted variants reverse inside switch; inside variants re-enter the switch and count the final travel from that edge.
// - Search speed 1..13200 rpm, default 60, clamped to ramp speed ceiling.
// - Exit speed 1..3000 rpm, default 6, clamped to ramp speed ceiling.
// - Nonzero edge-search limit exceeded without edge aborts homing with error.
// - After overrun the switch must reactivate within nonzero limit, else cancel.
// - Successful homing loads the home position value as current position.
// - Preset write sets position directly, unscaled, only at standstill.
// - Without index, travel working area offset past edge, default 200, then reference.
// - Index methods capture the distance from the last stored switch edge to the index as a readable value.
// - Reference switch is evaluated only while homing runs.
`timescale 1ns/10ps
module homing_reference_control
(
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Parameter port
  input  wire homing_pkg::param_req_s paramReq,
  output logic [31:0]            paramRdData,
  output logic                   paramRdValid,
  // Switch and encoder pins
  input  wire homing_pkg::pins_s pins,
  // Motion interface
  input  wire logic [15:0]       rampSpeedCeiling,
  input  wire logic              standstill,
  output logic [15:0]            speedCmd,
  output logic                   moveDir,
  output logic                   homingBusy,
  output logic                   homingDone,
  output logic                   homingError,
  output logic [31:0]            positionValue
);
  import homing_pkg::*;
  function automatic method_s decode(input logic [15:0] code);
    method_s     m;
    logic [15:0] k;
    m = '0;
    k = HALF_ZERO;
    if (code == METH_NEGATIVE_LIMIT_SWITCH_IDX || code == METH_POSITIVE_LIMIT_SWITCH_IDX || code == METH_NEGATIVE_LIMIT_SWITCH
        || code == METH_POSITIVE_LIMIT_SWITCH)
    begin
      m.valid     = 1'b1;
      m.useLimit  = 1'b1;
      m.invert    = 1'b1;
      m.outside   = 1'b1;
      m.useIndex  = (code == METH_NEGATIVE_LIMIT_SWITCH_IDX) || (code == METH_POSITIVE_LIMIT_SWITCH_IDX);
      m.posSearch = (code == METH_POSITIVE_LIMIT_SWITCH_IDX) || (code == METH_POSITIVE_LIMIT_SWITCH);
    end
    else if ((code >= METH_REF_IDX_LO && code <= METH_REF_IDX_HI)
             || (code >= METH_REF_LO && code <= METH_REF_HI))
    begin
      k = (code <= METH_REF_IDX_HI) ? code - METH_REF_IDX_LO : code - METH_REF_LO;
      m.valid     = 1'b1;
      m.useRef    = 1'b1;
      m.useIndex  = (code <= METH_REF_IDX_HI);
      m.posSearch = ~k[2];
      m.invert    = ~k[1];
      m.outside   = ~(k[1] ^ k[0]);
    end
    else if (code == METH_IDX_NEG || code == METH_IDX_POS)
    begin
      m.valid     = 1'b1;
      m.useIndex  = 1'b1;
      m.posSearch = (code == METH_IDX_POS);
    end
    return m;
  endfunction
  function automatic logic [15:0] clampSpd(input logic [15:0] s, input logic [15:0] c);
    return (s > c) ? c : s;
  endfunction
  // Pin synchronisers and edge memory
  pins_s metaReg, syncReg, prevReg;
  pins_s metaNext, syncNext, prevNext;
  // Parameters
  logic [15:0] method_reg, searchSpd_reg, exitSpd_reg;
  logic [15:0] method_next, searchSpd_next, exitSpd_next;
  logic [31:0] edgeLim_reg, workOfs_reg, homePos_reg, ovrLim_reg;
  logic [31:0] edgeLim_next, workOfs_next, homePos_next, ovrLim_next;
  logic [31:0] rdData_reg, rdData_next;
  logic        rdValid_reg, rdValid_next;
  // Sequencer
  state_e      state_reg, state_next;
  method_s     meth_reg, meth_next, methDec;
  logic [15:0] speed_reg, speed_next;
  logic        dir_reg, dir_next;
  logic        done_reg, done_next, error_reg, error_next, refused_reg, refused_next;
  logic [31:0] dist_reg, dist_next, edgePos_reg, edgePos_next;
  logic [31:0] idxDist_reg, idxDist_next, pos_reg, pos_next;
  logic        busy_reg, busy_next;
  logic stepEv, indexEv, refAct, swAct, startWr, presetWr, homeLoad;
  assign methDec  = decode(method_reg);
  assign stepEv   = syncReg.stepPulse & ~prevReg.stepPulse;
  assign indexEv  = syncReg.indexPulse & ~prevReg.indexPulse;
  assign refAct   = syncReg.refSw & (state_reg != ST_IDLE);
  assign swAct    = meth_reg.useRef ? refAct
                  : (meth_reg.posSearch ? syncReg.limPos : syncReg.limNeg);
  assign startWr  = paramReq.wr && paramReq.addr == ADDR_CONTROL
                  && paramReq.wrData[CTL_START];
  assign presetWr = paramReq.wr && paramReq.addr == ADDR_PRESET;
  always_comb
  begin
    metaNext       = pins;
    syncNext       = metaReg;
    prevNext       = syncReg;
    method_next    = method_reg;
    searchSpd_next = searchSpd_reg;
    exitSpd_next   = exitSpd_reg;
    edgeLim_next   = edgeLim_reg;
    workOfs_next   = workOfs_reg;
    homePos_next   = homePos_reg;
    ovrLim_next    = ovrLim_reg;
    rdValid_next   = paramReq.rd;
    rdData_next    = rdData_reg;
    if (paramReq.wr)
      case (paramReq.addr)
        ADDR_METHOD:     method_next = paramReq.wrData[15:0];
        // Out-of-range speeds are dropped so the last legal value stays
        ADDR_SEARCH_SPD: if (paramReq.wrData[15:0] >= SPD_MIN
                             && paramReq.wrData[15:0] <= SEARCH_SPD_MAX)
                           searchSpd_next = paramReq.wrData[15:0];
        ADDR_EXIT_SPD:   if (paramReq.wrData[15:0] >= SPD_MIN
                             && paramReq.wrData[15:0] <= EXIT_SPD_MAX)
                           exitSpd_next = paramReq.wrData[15:0];
        ADDR_EDGE_LIM:   if (!paramReq.wrData[31]) edgeLim_next = paramReq.wrData;
        ADDR_WORK_OFS:   if (!paramReq.wrData[31] && paramReq.wrData != WORD_ZERO)
                           workOfs_next = paramReq.wrData;
        ADDR_HOME_POS:   homePos_next = paramReq.wrData;
        ADDR_OVR_LIM:    if (!paramReq.wrData[31]) ovrLim_next = paramReq.wrData;
        default:         ;
      endcase
    if (paramReq.rd)
      case (paramReq.addr)
        ADDR_METHOD:     rdData_next = {HALF_ZERO, method_reg};
        ADDR_SEARCH_SPD: rdData_next = {HALF_ZERO, searchSpd_reg};
        ADDR_EXIT_SPD:   rdData_next = {HALF_ZERO, exitSpd_reg};
        ADDR_EDGE_LIM:   rdData_next = edgeLim_reg;
        ADDR_WORK_OFS:   rdData_next = workOfs_reg;
        ADDR_HOME_POS:   rdData_next = homePos_reg;
        ADDR_IDX_DIST:   rdData_next = idxDist_reg;
        ADDR_OVR_LIM:    rdData_next = ovrLim_reg;
        ADDR_POSITION:   rdData_next = pos_reg;
        ADDR_STATUS:
        begin
          rdData_next             = WORD_ZERO;
          rdData_next[ST_BUSY]    = (state_reg != ST_IDLE);
          rdData_next[ST_DONE]    = done_reg;
          rdData_next[ST_ERROR]   = error_reg;
          rdData_next[ST_REFUSED] = refused_reg;
        end
        default:         rdData_next = WORD_ZERO;
      endcase
  end
  always_comb
  begin
    state_next   = state_reg;
    meth_next    = meth_reg;
    speed_next   = speed_reg;
    dir_next     = dir_reg;
    done_next    = done_reg;
    error_next   = error_reg;
    refused_next = refused_reg;
    edgePos_next = edgePos_reg;
    idxDist_next = idxDist_reg;
    homeLoad     = 1'b0;
    dist_next    = (stepEv && state_reg != ST_IDLE) ? dist_reg + 32'h00000001 : dist_reg;
    case (state_reg)
      ST_IDLE:
      begin
        dist_next = WORD_ZERO;
        speed_next = HALF_ZERO;
        if (startWr && !methDec.valid)
          refused_next = 1'b1;
        else if (startWr)
        begin
          refused_next = 1'b0;
          done_next    = 1'b0;
          error_next   = 1'b0;
          meth_next    = methDec;
          dir_next     = methDec.posSearch;
          speed_next   = clampSpd(searchSpd_reg, rampSpeedCeiling);
          state_next   = (methDec.useRef || methDec.useLimit) ? ST_SEARCH : ST_FINAL;
        end
      end
      ST_SEARCH:
        if (swAct)
        begin
          state_next = ST_LEAVE;
          dir_next   = dir_reg ^ meth_reg.invert;
          speed_next = clampSpd(exitSpd_reg, rampSpeedCeiling);
          dist_next  = WORD_ZERO;
        end
      ST_LEAVE:
        if (!swAct)
        begin
          edgePos_next = pos_reg;
          dist_next    = WORD_ZERO;
          if (meth_reg.outside)
            state_next = ST_FINAL;
          else
          begin
            state_next = ST_REENTER;
            dir_next   = ~dir_reg;
          end
        end
        else if (edgeLim_reg != WORD_ZERO && dist_reg > edgeLim_reg)
        begin
          state_next = ST_IDLE;
          error_next = 1'b1;
          speed_next = HALF_ZERO;
        end
      ST_REENTER:
        if (swAct)
        begin
          state_next = ST_FINAL;
          dist_next  = WORD_ZERO;
        end
        else if (ovrLim_reg != WORD_ZERO && dist_reg > ovrLim_reg)
        begin
          state_next = ST_IDLE;
          error_next = 1'b1;
          speed_next = HALF_ZERO;
        end
      ST_FINAL:
        if (meth_reg.useIndex ? indexEv : (dist_reg >= workOfs_reg))
        begin
          if (meth_reg.useIndex)
            idxDist_next = pos_reg - edgePos_reg;
          homeLoad   = 1'b1;
          state_next = ST_IDLE;
          done_next  = 1'b1;
          speed_next = HALF_ZERO;
        end
      default:
        state_next = ST_IDLE;
    endcase
    // Home load outranks preset and step counting in the same cycle
    if (homeLoad)
      pos_next = homePos_reg;
    else if (presetWr && standstill && state_reg == ST_IDLE)
      pos_next = paramReq.wrData;
    else if (stepEv)
      pos_next = syncReg.stepDir ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;
    else
      pos_next = pos_reg;
    // Busy leaves a flop so the output carries no decode glitches
    busy_next = (state_next != ST_IDLE);
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      metaReg       <= '0;
      syncReg       <= '0;
      prevReg       <= '0;
      method_reg    <= METHOD_RST;
      searchSpd_reg <= SEARCH_SPD_RST;
      exitSpd_reg   <= EXIT_SPD_RST;
      edgeLim_reg   <= WORD_ZERO;
      workOfs_reg   <= WORK_OFS_RST;
      homePos_reg   <= WORD_ZERO;
      ovrLim_reg    <= WORD_ZERO;
      rdData_reg    <= WORD_ZERO;
      rdValid_reg   <= 1'b0;
      state_reg     <= ST_IDLE;
      meth_reg      <= '0;
      speed_reg     <= HALF_ZERO;
      dir_reg       <= 1'b0;
      done_reg      <= 1'b0;
      error_reg     <= 1'b0;
      refused_reg   <= 1'b0;
      dist_reg      <= WORD_ZERO;
      edgePos_reg   <= WORD_ZERO;
      idxDist_reg   <= WORD_ZERO;
      pos_reg       <= WORD_ZERO;
      busy_reg      <= 1'b0;
    end
    else if (ce)
    begin
      metaReg       <= metaNext;
      syncReg       <= syncNext;
      prevReg       <= prevNext;
      method_reg    <= method_next;
      searchSpd_reg <= searchSpd_next;
      exitSpd_reg   <= exitSpd_next;
      edgeLim_reg   <= edgeLim_next;
      workOfs_reg   <= workOfs_next;
      homePos_reg   <= homePos_next;
      ovrLim_reg    <= ovrLim_next;
      rdData_reg    <= rdData_next;
      rdValid_reg   <= rdValid_next;
      state_reg     <= state_next;
      meth_reg      <= meth_next;
      speed_reg     <= speed_next;
      dir_reg       <= dir_next;
      done_reg      <= done_next;
      error_reg     <= error_next;
      refused_reg   <= refused_next;
      dist_reg      <= dist_next;
      edgePos_reg   <= edgePos_next;
      idxDist_reg   <= idxDist_next;
      pos_reg       <= pos_next;
      busy_reg      <= busy_next;
    end
  end
  assign paramRdData   = rdData_reg;
  assign paramRdValid  = rdValid_reg;
  assign speedCmd      = speed_reg;
  assign moveDir       = dir_reg;
  assign homingBusy    = busy_reg;
  assign homingDone    = done_reg;
  assign homingError   = error_reg;
  assign positionValue = pos_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  method_off_a: assert property (method_reg == METH_OFF |-> !methDec.valid)
    else $error("method zero decoded as valid");
  ref_idx_pos_a: assert property (method_reg inside {[METH_REF_IDX_LO:16'h000A]}
      |-> methDec.useRef && methDec.useIndex && methDec.posSearch)
    else $error("reference-with-index method decoded wrongly");
  lim_no_idx_a: assert property (method_reg == METH_NEGATIVE_LIMIT_SWITCH |-> methDec.useLimit
      && !methDec.useIndex && !methDec.posSearch)
    else $error("negative limit method decoded wrongly");
  idx_only_a: assert property (method_reg == METH_IDX_POS |-> methDec.useIndex
      && !methDec.useRef && !methDec.useLimit && methDec.posSearch)
    else $error("index-only method decoded wrongly");
  invert_dir_a: assert property (ce && state_reg == ST_SEARCH && state_next == ST_LEAVE
      |=> dir_reg == ($past(dir_reg) ^ meth_reg.invert))
    else $error("direction not handled in switch");
  search_clamp_a: assert property (ce && state_reg == ST_IDLE && state_next == ST_SEARCH
      |=> speed_reg <= searchSpd_reg && speed_reg <= $past(rampSpeedCeiling))
    else $error("search speed above limit");
  exit_clamp_a: assert property (ce && state_reg == ST_SEARCH && state_next == ST_LEAVE
      |=> speed_reg <= exitSpd_reg && speed_reg <= $past(rampSpeedCeiling))
    else $error("exit speed above limit");
  edge_abort_a: assert property (ce && state_reg == ST_LEAVE && swAct
      && edgeLim_reg != WORD_ZERO && dist_reg > edgeLim_reg
      |=> error_reg && state_reg == ST_IDLE && speed_reg == HALF_ZERO)
    else $error("edge search overrun not aborted");
  overrun_abort_a: assert property (ce && state_reg == ST_REENTER && !swAct
      && ovrLim_reg != WORD_ZERO && dist_reg > ovrLim_reg
      |=> error_reg && state_reg == ST_IDLE)
    else $error("overrun search not cancelled");
  home_load_a: assert property (ce && state_reg == ST_FINAL && state_next == ST_IDLE
      |=> pos_reg == $past(homePos_reg) && done_reg)
    else $error("home position not loaded");
  preset_a: assert property (ce && presetWr && standstill && state_reg == ST_IDLE
      |=> pos_reg == $past(paramReq.wrData))
    else $error("preset not applied");
  idx_capture_a: assert property (ce && state_reg == ST_FINAL && meth_reg.useIndex
      && indexEv |=> idxDist_reg == $past(pos_reg) - $past(edgePos_reg))
    else $error("edge-to-index distance not captured");
  ref_idle_a: assert property (state_reg == ST_IDLE |-> !refAct)
    else $error("reference switch seen while idle");
  refuse_start_a: assert property (ce && state_reg == ST_IDLE && startWr
      && !methDec.valid |=> state_reg == ST_IDLE && speed_reg == HALF_ZERO && refused_reg)
    else $error("invalid start not refused");
  homed_c:   cover property (ce && state_reg == ST_FINAL ##1 done_reg);
  aborted_c: cover property (state_reg == ST_LEAVE ##1 error_reg);
  refused_c: cover property (ce && startWr && !methDec.valid);
  reenter_c: cover property (state_reg == ST_REENTER ##1 state_reg == ST_FINAL);
endmodule

// >>> src/homing_pkg.sv
package homing_pkg;

  // Parameter addresses on the fieldbus parameter port
  localparam logic [15:0] ADDR_METHOD     = 16'h2800;
  localparam logic [15:0] ADDR_SEARCH_SPD = 16'h2808;
  localparam logic [15:0] ADDR_EXIT_SPD   = 16'h280A;
  localparam logic [15:0] ADDR_EDGE_LIM   = 16'h280C;
  localparam logic [15:0] ADDR_WORK_OFS   = 16'h280E;
  localparam logic [15:0] ADDR_HOME_POS   = 16'h2816;
  localparam logic [15:0] ADDR_IDX_DIST   = 16'h2818;
  localparam logic [15:0] ADDR_OVR_LIM    = 16'h281A;
  localparam logic [15:0] ADDR_PRESET     = 16'h2830;
  localparam logic [15:0] ADDR_CONTROL    = 16'h2840;
  localparam logic [15:0] ADDR_STATUS     = 16'h2842;
  localparam logic [15:0] ADDR_POSITION   = 16'h2844;

  // Reset values and limits
  localparam logic [15:0] METHOD_RST     = 16'h0000;
  localparam logic [15:0] SEARCH_SPD_RST = 16'h003C;
  localparam logic [15:0] EXIT_SPD_RST   = 16'h0006;
  localparam logic [15:0] SPD_MIN        = 16'h0001;
  localparam logic [15:0] SEARCH_SPD_MAX = 16'h3390;
  localparam logic [15:0] EXIT_SPD_MAX   = 16'h0BB8;
  localparam logic [31:0] WORK_OFS_RST   = 32'h000000C8;
  localparam logic [31:0] WORD_ZERO      = 32'h00000000;
  localparam logic [15:0] HALF_ZERO      = 16'h0000;

  // Method codes
  localparam logic [15:0] METH_OFF       = 16'h0000;
  localparam logic [15:0] METH_NEGATIVE_LIMIT_SWITCH_IDX  = 16'h0001;
  localparam logic [15:0] METH_POSITIVE_LIMIT_SWITCH_IDX  = 16'h0002;
  localparam logic [15:0] METH_REF_IDX_LO = 16'h0007;
  localparam logic [15:0] METH_REF_IDX_HI = 16'h000E;
  localparam logic [15:0] METH_NEGATIVE_LIMIT_SWITCH      = 16'h0011;
  localparam logic [15:0] METH_POSITIVE_LIMIT_SWITCH      = 16'h0012;
  localparam logic [15:0] METH_REF_LO    = 16'h0017;
  localparam logic [15:0] METH_REF_HI    = 16'h001E;
  localparam logic [15:0] METH_IDX_NEG   = 16'h001F;
  localparam logic [15:0] METH_IDX_POS   = 16'h0022;

  // Control and status bit positions
  localparam int CTL_START  = 0;
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_ERROR   = 2;
  localparam int ST_REFUSED = 3;

  typedef struct packed {
    logic valid;
    logic useRef;
    logic useLimit;
    logic useIndex;
    logic posSearch;
    logic invert;
    logic outside;
  } method_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wrData;
    logic        wr;
    logic        rd;
  } param_req_s;

  typedef struct packed {
    logic limNeg;
    logic limPos;
    logic refSw;
    logic indexPulse;
    logic stepPulse;
    logic stepDir;
  } pins_s;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_SEARCH  = 5'b00010,
    ST_LEAVE   = 5'b00100,
    ST_REENTER = 5'b01000,
    ST_FINAL   = 5'b10000
  } state_e;

endpackage

// >>> dv/homing_axis_model.sv
`timescale 1ns/10ps
module homing_axis_model
  import homing_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Drive command
  input  wire logic [15:0]  speedCmd,
  input  wire logic         moveDir,
  // Sensed axis
  output homing_pkg::pins_s pins,
  output logic              standstill
);
  // One step every four clocks at any speed: the block only counts steps
  int         axisPos;
  logic [1:0] phase;
  logic       stepped;
  logic       lastDir;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      axisPos <= 0;
      phase   <= 2'h0;
      stepped <= 1'b0;
      lastDir <= 1'b0;
    end
    else
    begin
      stepped <= 1'b0;
      if (speedCmd != 16'h0000)
      begin
        phase <= phase + 2'h1;
        if (phase == 2'h3)
        begin
          axisPos <= moveDir ? axisPos + 1 : axisPos - 1;
          stepped <= 1'b1;
          lastDir <= moveDir;
        end
      end
    end
  end

  // Limits beyond +-100, reference over 30..60, index every 40 counts
  always_comb
  begin
    pins.limNeg     = axisPos < -100;
    pins.limPos     = axisPos > 100;
    pins.refSw      = axisPos >= 30 && axisPos <= 60;
    pins.indexPulse = axisPos % 40 == 0;
    pins.stepPulse  = stepped;
    pins.stepDir    = lastDir;
    standstill      = speedCmd == 16'h0000;
  end
endmodule

// >>> dv/homing_reference_control_tb_top.sv
`timescale 1ns/10ps
module homing_reference_control_tb_top;
  import homing_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  param_req_s  paramReq = '0;
  logic [15:0] rampSpeedCeiling = 16'h3390;
  pins_s       pins;
  logic        standstill;
  logic [31:0] paramRdData;
  logic        paramRdValid;
  logic [15:0] speedCmd;
  logic        moveDir;
  logic        homingBusy;
  logic        homingDone;
  logic        homingError;
  logic [31:0] positionValue;
  logic [31:0] rdVal;
  int          err_total = 0;
  int          checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  homing_reference_control uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .paramReq(paramReq), .paramRdData(paramRdData), .paramRdValid(paramRdValid),
    .pins(pins), .rampSpeedCeiling(rampSpeedCeiling), .standstill(standstill),
    .speedCmd(speedCmd), .moveDir(moveDir), .homingBusy(homingBusy),
    .homingDone(homingDone), .homingError(homingError), .positionValue(positionValue));

  homing_axis_model axis (.sys_clk(sys_clk), .rst_n(rst_n), .speedCmd(speedCmd),
    .moveDir(moveDir), .pins(pins), .standstill(standstill));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    paramReq.addr = a;
    paramReq.wrData = d;
    paramReq.wr = 1'b1;
    @(negedge sys_clk);
    paramReq.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(negedge sys_clk);
    paramReq.addr = a;
    paramReq.rd = 1'b1;
    @(negedge sys_clk);
    paramReq.rd = 1'b0;
    for (int i = 0; i < 3 && paramRdValid !== 1'b1; i++)
      @(negedge sys_clk);
    chk({31'h0, paramRdValid}, 32'h1, "read answer");
    rdVal = paramRdData;
  endtask

  // Start is only written while idle, so busy must rise within a few clocks
  task automatic startRun(input logic [15:0] m, input logic d, input logic [15:0] s);
    wr(ADDR_METHOD, {16'h0000, m});
    wr(ADDR_CONTROL, 32'h00000001);
    for (int i = 0; i < 3 && homingBusy !== 1'b1; i++)
      @(negedge sys_clk);
    chk({31'h0, homingBusy}, 32'h1, "busy");
    chk({31'h0, moveDir}, {31'h0, d}, "direction");
    chk({16'h0, speedCmd}, {16'h0, s}, "search speed");
  endtask

  task automatic waitEnd(input logic expErr);
    for (int i = 0; i < 4000 && homingBusy !== 1'b0; i++)
      @(negedge sys_clk);
    chk({30'h0, homingDone, homingError}, {30'h0, !expErr, expErr}, "end flags");
  endtask

  task automatic t_defaults();
    logic [15:0] a [7] = '{ADDR_METHOD, ADDR_SEARCH_SPD, ADDR_EXIT_SPD, ADDR_EDGE_LIM,
                           ADDR_OVR_LIM, ADDR_HOME_POS, ADDR_WORK_OFS};
    logic [31:0] e [7] = '{32'h0, 32'h3C, 32'h6, 32'h0, 32'h0, 32'h0, 32'hC8};
    for (int i = 0; i < 7; i++)
    begin
      rd(a[i]);
      chk(rdVal, e[i], "default");
    end
  endtask

  task automatic t_speedRange();
    logic [15:0] a [5] = '{ADDR_SEARCH_SPD, ADDR_SEARCH_SPD, ADDR_SEARCH_SPD,
                           ADDR_EXIT_SPD, ADDR_EXIT_SPD};
    logic [31:0] d [5] = '{32'h0, 32'h3391, 32'h3390, 32'hBB9, 32'hBB8};
    logic [31:0] e [5] = '{32'h3C, 32'h3C, 32'h3390, 32'h6, 32'hBB8};
    for (int i = 0; i < 5; i++)
    begin
      wr(a[i], d[i]);
      rd(a[i]);
      chk(rdVal, e[i], "speed range");
    end
    wr(ADDR_EXIT_SPD, 32'h6);
  endtask

  task automatic t_refuse();
    logic [15:0] m [2] = '{16'h0000, 16'h0003};
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_METHOD, {16'h0000, m[i]});
      wr(ADDR_CONTROL, 32'h00000001);
      rd(ADDR_STATUS);
      chk(rdVal, 32'h8, "refused status");
      chk({speedCmd, 15'h0, homingBusy}, 32'h0, "no motion");
      chk(positionValue, 32'h0, "position kept");
    end
  endtask

  task automatic t_preset();
    wr(ADDR_PRESET, 32'h80000001);
    chk(positionValue, 32'h80000001, "preset");
    rd(ADDR_POSITION);
    chk(rdVal, 32'h80000001, "position read");
  endtask

  task automatic t_edgeAbort();
    wr(ADDR_EDGE_LIM, 32'hA);
    startRun(16'h001A, 1'b1, 16'h0028);
    waitEnd(1'b1);
    rd(ADDR_STATUS);
    chk(rdVal, 32'h4, "abort status");
    wr(ADDR_EDGE_LIM, 32'h0);
  endtask

  task automatic t_indexOnly();
    startRun(METH_IDX_POS, 1'b1, 16'h0028);
    waitEnd(1'b0);
    chk(positionValue, 32'h0, "home load");
    startRun(METH_IDX_NEG, 1'b0, 16'h0028);
    waitEnd(1'b0);
  endtask

  task automatic t_limitHome();
    wr(ADDR_HOME_POS, 32'hFFFFF000);
    startRun(METH_NEGATIVE_LIMIT_SWITCH, 1'b0, 16'h0028);
    wr(ADDR_PRESET, 32'h55AA55AA);
    chk({31'h0, positionValue === 32'h55AA55AA}, 32'h0, "preset while moving");
    for (int i = 0; i < 2000 && moveDir !== 1'b1; i++)
      @(negedge sys_clk);
    chk({16'h0, speedCmd}, 32'h6, "exit speed");
    waitEnd(1'b0);
    chk(positionValue, 32'hFFFFF000, "home value");
    chk({31'h0, axis.axisPos inside {[99:101]}}, 32'h1, "offset travel");
  endtask

  // Negative reference search that re-enters the switch and counts the offset from that edge
  task automatic t_insideHome();
    wr(ADDR_OVR_LIM, 32'h00000005);
    startRun(16'h001D, 1'b0, 16'h0028);
    for (int i = 0; i < 2000 && moveDir !== 1'b1; i++)
      @(negedge sys_clk);
    chk({16'h0, speedCmd}, 32'h6, "re-entry speed");
    waitEnd(1'b0);
    chk(positionValue, 32'hFFFFF000, "inside home value");
    chk({31'h0, axis.axisPos inside {[229:232]}}, 32'h1, "inside offset travel");
    wr(ADDR_OVR_LIM, 32'h00000000);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #500000;
    err_total++;
    $display("BAD %0t timeout", $time);
    print_verdict();
  end

  initial
  begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    t_defaults();
    t_speedRange();
    t_refuse();
    t_preset();
    rampSpeedCeiling = 16'h0028;
    t_edgeAbort();
    t_indexOnly();
    t_limitHome();
    t_insideHome();
    print_verdict();
  end
endmodule
